// >>> rtl/spfc_params.svh
// Register offsets, field positions, reset values and turnaround length
// Summary of operation
// - Pull-up disable bit turns parport pull-ups off
// - Tx wait: four char delay rx-to-tx
// - Rx wait: four char delay tx-to-rx
// - Priority bit picks bank or config IR select
// - IRQ A pin becomes general IO one
// - IRQ B pin becomes general IO zero
// - Secondary IR turns chip selects into IR
// - Upper nibble picks transmit DMA channel
// - Lower nibble picks receive DMA channel
// - Two bits choose first shared pin function
// - Two bits choose second shared pin function
// - Two bits choose third shared pin function
// - Two bits choose interrupt input pin function
// - Three bits choose data buffer pin function
// - Bank mode bit picks select zero or rx
// - CRC append bit adds CRC in fast modes
// - Bank select enable gates bank selection
// - Clock select bit: 48 or 24 MHz
// - Drive A rate table plus rate bits
// - Drive B uses the same rate mapping
// - Drive A precompensation disable bit
// - Drive B precompensation disable bit
`ifndef SPFC_PARAMS_SVH
`define SPFC_PARAMS_SVH

// Byte addresses of the registers
`define SPFC_ADDR_TURN      8'h00
`define SPFC_ADDR_PRIO      8'h04
`define SPFC_ADDR_IRQGIO    8'h08
`define SPFC_ADDR_FIRDMA    8'h0c
`define SPFC_ADDR_PINFA     8'h10
`define SPFC_ADDR_PINFB     8'h14
`define SPFC_ADDR_FLOPPY    8'h18
`define SPFC_ADDR_EXT       8'h1c
`define SPFC_ADDR_STATUS    8'h20

// Reset values
`define SPFC_RST_TURN       8'h00
`define SPFC_RST_PRIO       8'h28
`define SPFC_RST_IRQGIO     8'h1e
`define SPFC_RST_FIRDMA     8'h00
`define SPFC_RST_PINFA      8'h00
`define SPFC_RST_PINFB      8'h10
`define SPFC_RST_FLOPPY     8'h00

// Field positions
`define SPFC_B_PULLUP       7
`define SPFC_B_TXWAIT       6
`define SPFC_B_RXWAIT       5
`define SPFC_B_BANKPRIO     4
`define SPFC_B_IRQA         5
`define SPFC_B_IRQB         4
`define SPFC_B_SECIR        1
`define SPFC_B_CRC          4
`define SPFC_B_BANKSEL      3
`define SPFC_B_CLKSEL       2
`define SPFC_B_PRECA        2
`define SPFC_B_PRECB        5
`define SPFC_B_EXT_IR_SELECT_ZERO    0
`define SPFC_B_EXT_RATE_SEL_LO   1

// Four character times of turnaround
`define SPFC_TURN_CHARS     4

`endif

// >>> rtl/spfc_pkg.sv
// Types shared by the pin function configuration block
`default_nettype none
package spfc_pkg;
  // Floppy data rates
  typedef enum logic [2:0] {
    SPFC_R_1M   = 3'h0,
    SPFC_R_500K = 3'h1,
    SPFC_R_300K = 3'h2,
    SPFC_R_250K = 3'h3,
    SPFC_R_2M   = 3'h4
  } spfc_rate_type;

  // Turnaround state, one-hot
  typedef enum logic [2:0] {
    SPFC_T_IDLE = 3'h1,
    SPFC_T_WAIT = 3'h2,
    SPFC_T_GO   = 3'h4
  } spfc_turn_type;

  // Pin function controls driven out
  typedef struct packed {
    logic       pullup_disable;
    logic       irq_a_gio_sel;
    logic       irq_b_gio_sel;
    logic       secondary_ir_enable;
    logic [4:0] fir_tx_dma_onehot;
    logic [4:0] fir_rx_dma_onehot;
    logic [1:0] first_pin_func;
    logic [1:0] second_pin_func;
    logic [1:0] third_pin_func;
    logic [1:0] irq_input_pin_func;
    logic [2:0] buffer_pin_func;
    logic       third_pin_is_sel0;
    logic       irq_in_pin_is_sel0;
    logic       buffer_pin_is_sel0;
    logic       bank_ir_priority;
    logic       crc_append;
    logic       bank_select_enable;
    logic       crystal_freq_sel;
    logic       drive_a_precomp_off;
    logic       drive_b_precomp_off;
  } spfc_pins_type;

  // All state of the block
  typedef struct packed {
    logic [7:0]    turn;
    logic [7:0]    prio;
    logic [7:0]    irqgio;
    logic [7:0]    firdma;
    logic [7:0]    pinfa;
    logic [7:0]    pinfb;
    logic [7:0]    floppy;
    logic [1:0]    ext;
    logic          awv;
    logic [7:0]    awaddr;
    logic          wv;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [1:0]    mode_s1;
    logic [1:0]    mode_s2;
    logic          prev_tx;
    spfc_turn_type turn_st;
    logic [1:0]    turn_cnt;
    logic          tx_allow;
    logic          rx_allow;
    spfc_rate_type rate_a;
    spfc_rate_type rate_b;
    logic          fm_a;
    logic          fm_b;
    spfc_pins_type pins;
  } spfc_state_type;
endpackage
`default_nettype wire

// >>> rtl/spfc_top.sv
// Pin function configuration register bank with AXI4-Lite slave
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "spfc_params.svh"
`default_nettype none
module spfc_top (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // AXI4-Lite write address and data
  input  wire logic                  AWVALID_I,
  output logic                       AWREADY_O,
  input  wire logic [7:0]            AWADDR_I,
  input  wire logic                  WVALID_I,
  output logic                       WREADY_O,
  input  wire logic [31:0]           WDATA_I,
  input  wire logic [3:0]            WSTRB_I,
  // AXI4-Lite write response
  output logic                       BVALID_O,
  input  wire logic                  BREADY_I,
  output logic [1:0]                 BRESP_O,
  // AXI4-Lite read
  input  wire logic                  ARVALID_I,
  output logic                       ARREADY_O,
  input  wire logic [7:0]            ARADDR_I,
  output logic                       RVALID_O,
  input  wire logic                  RREADY_I,
  output logic [31:0]                RDATA_O,
  output logic [1:0]                 RRESP_O,
  // Serial infrared link direction and character tick (same clock)
  input  wire logic                  IR_TX_DIR_I,
  input  wire logic                  IR_CHAR_TICK_I,
  // Bank register bits from the serial port (other logic, same clock)
  input  wire logic                  BANK_IR_SELECT_ZERO_MODE_I,
  input  wire logic [1:0]            RATE_SEL_I,
  // Pin controls and derived settings
  output spfc_pkg::spfc_pins_type    PINS_O,
  output logic                       TX_ALLOW_O,
  output logic                       RX_ALLOW_O,
  output spfc_pkg::spfc_rate_type    RATE_A_O,
  output spfc_pkg::spfc_rate_type    RATE_B_O,
  output logic                       FM_A_O,
  output logic                       FM_B_O
);

  ////////////////////////////////////////////////////////////////////////
  // State registers
  spfc_pkg::spfc_state_type st_r;    // Present state
  spfc_pkg::spfc_state_type st_nxt;  // Next state

  // Rate lookup shared by both drives
  function automatic spfc_pkg::spfc_rate_type rate_of(
    input logic [1:0] table_sel,
    input logic [1:0] rsel
  );
    spfc_pkg::spfc_rate_type r;
    r = spfc_pkg::SPFC_R_500K;
    if (rsel == 2'h3) begin
      r = spfc_pkg::SPFC_R_1M;
    end else if (rsel == 2'h2) begin
      r = spfc_pkg::SPFC_R_250K;
    end else if (rsel == 2'h1) begin
      // Table code 11 is undefined; it falls back to table 00
      case (table_sel)
        2'h1:    r = spfc_pkg::SPFC_R_500K;
        2'h2:    r = spfc_pkg::SPFC_R_2M;
        default: r = spfc_pkg::SPFC_R_300K;
      endcase
    end
    return r;
  endfunction

  // Nibble code to one-hot channel strobe, bit 0 means none
  function automatic logic [4:0] dma_onehot(input logic [3:0] code);
    logic [4:0] oh;
    oh = 5'h01;
    // Codes above four select no channel rather than alias
    if (code <= 4'h4) begin
      oh = 5'h01 << code;
    end
    return oh;
  endfunction

  // Register read mux
  function automatic logic [31:0] read_reg(
    input spfc_pkg::spfc_state_type s,
    input logic [7:0] a,
    output logic ok
  );
    logic [31:0] d;
    d  = 32'h0000_0000;
    ok = 1'b1;
    case (a)
      `SPFC_ADDR_TURN:   d = {24'h000000, s.turn};
      `SPFC_ADDR_PRIO:   d = {24'h000000, s.prio};
      `SPFC_ADDR_IRQGIO: d = {24'h000000, s.irqgio};
      `SPFC_ADDR_FIRDMA: d = {24'h000000, s.firdma};
      `SPFC_ADDR_PINFA:  d = {24'h000000, s.pinfa};
      `SPFC_ADDR_PINFB:  d = {24'h000000, s.pinfb};
      `SPFC_ADDR_FLOPPY: d = {24'h000000, s.floppy};
      `SPFC_ADDR_EXT:    d = {30'h0, s.ext};
      // Live status: turnaround gates, rates, FM flags
      `SPFC_ADDR_STATUS: d = {16'h0000, 2'h0, s.fm_b, s.fm_a,
                              1'b0, s.rate_b, 1'b0, s.rate_a,
                              2'h0, s.rx_allow, s.tx_allow};
      default: begin
        ok = 1'b0;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state logic
  always_comb begin
    logic [31:0] rd;
    logic        rd_ok;
    logic [7:0]  wb;
    logic        do_wr;
    logic        ir_select_zero_mode;
    logic [1:0]  rsel;
    logic [1:0]  ta;
    logic [1:0]  tb;
    rd     = 32'h0000_0000;
    rd_ok  = 1'b0;
    wb     = 8'h00;
    do_wr      = 1'b0;
    ir_select_zero_mode = 1'b0;
    rsel       = 2'h0;
    ta         = 2'h0;
    tb         = 2'h0;
    st_nxt = st_r;

    // Capture write address and data in either order
    if (!st_r.awv && AWVALID_I) begin
      st_nxt.awv    = 1'b1;
      st_nxt.awaddr = AWADDR_I;
    end
    if (!st_r.wv && WVALID_I) begin
      st_nxt.wv    = 1'b1;
      st_nxt.wdata = WDATA_I;
      st_nxt.wstrb = WSTRB_I;
    end

    // Retire write once both halves are held and no response pends
    do_wr = st_r.awv && st_r.wv && !st_r.bvalid;
    if (do_wr) begin
      wb = st_r.wstrb[0] ? st_r.wdata[7:0] : 8'h00;
      st_nxt.awv    = 1'b0;
      st_nxt.wv     = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'h0;
      if (st_r.wstrb[0]) begin
        case (st_r.awaddr)
          `SPFC_ADDR_TURN:   st_nxt.turn   = wb;
          `SPFC_ADDR_PRIO:   st_nxt.prio   = wb;
          `SPFC_ADDR_IRQGIO: st_nxt.irqgio = wb;
          `SPFC_ADDR_FIRDMA: st_nxt.firdma = wb;
          `SPFC_ADDR_PINFA:  st_nxt.pinfa  = wb;
          // Bit 1 is reserved and stays zero
          `SPFC_ADDR_PINFB:  st_nxt.pinfb  = {wb[7:2], 1'b0, wb[0]};
          `SPFC_ADDR_FLOPPY: st_nxt.floppy = {2'h0, wb[5:0]};
          `SPFC_ADDR_EXT:    st_nxt.ext    = wb[1:0];
          `SPFC_ADDR_STATUS: begin
            // Status is read only; write ignored with OKAY
          end
          default: st_nxt.bresp = 2'h2;
        endcase
      end else begin
        // Strobe off: unmapped still gets SLVERR
        rd = read_reg(st_r, st_r.awaddr, rd_ok);
        if (!rd_ok) begin
          st_nxt.bresp = 2'h2;
        end
      end
    end
    if (st_r.bvalid && BREADY_I) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read channel: accept, then answer next cycle
    st_nxt.arready = 1'b0;
    if (st_r.rvalid && RREADY_I) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ARVALID_I && !st_r.arready && !st_r.rvalid) begin
      st_nxt.arready = 1'b1;
      rd = read_reg(st_r, ARADDR_I, rd_ok);
      st_nxt.rdata  = rd;
      st_nxt.rresp  = rd_ok ? 2'h0 : 2'h2;
    end
    if (st_r.arready) begin
      st_nxt.rvalid = 1'b1;
    end

    // Bank mode bit may come from the bank or from the config copy
    ir_select_zero_mode = st_r.prio[`SPFC_B_BANKPRIO]
               ? BANK_IR_SELECT_ZERO_MODE_I : st_r.ext[`SPFC_B_EXT_IR_SELECT_ZERO];
    // Rate bits follow the same priority
    rsel = st_r.prio[`SPFC_B_BANKPRIO] ? RATE_SEL_I
         : {1'b0, st_r.ext[`SPFC_B_EXT_RATE_SEL_LO]};

    // Pin function decode
    st_nxt.pins.pullup_disable      = st_r.turn[`SPFC_B_PULLUP];
    st_nxt.pins.irq_a_gio_sel       = st_r.irqgio[`SPFC_B_IRQA];
    st_nxt.pins.irq_b_gio_sel       = st_r.irqgio[`SPFC_B_IRQB];
    st_nxt.pins.secondary_ir_enable = st_r.irqgio[`SPFC_B_SECIR];
    st_nxt.pins.fir_tx_dma_onehot   = dma_onehot(st_r.firdma[7:4]);
    st_nxt.pins.fir_rx_dma_onehot   = dma_onehot(st_r.firdma[3:0]);
    st_nxt.pins.first_pin_func      = st_r.pinfa[7:6];
    st_nxt.pins.second_pin_func     = st_r.pinfa[5:4];
    st_nxt.pins.third_pin_func      = st_r.pinfa[3:2];
    st_nxt.pins.irq_input_pin_func  = st_r.pinfa[1:0];
    // Codes above four fall back to interrupt H
    st_nxt.pins.buffer_pin_func     = (st_r.pinfb[7:5] > 3'h4)
                                    ? 3'h0 : st_r.pinfb[7:5];
    st_nxt.pins.third_pin_is_sel0   =
      (st_r.pinfa[3:2] == 2'h3) && ir_select_zero_mode;
    st_nxt.pins.irq_in_pin_is_sel0  =
      (st_r.pinfa[1:0] == 2'h3) && ir_select_zero_mode;
    st_nxt.pins.buffer_pin_is_sel0  =
      (st_r.pinfb[7:5] == 3'h3) && ir_select_zero_mode;
    st_nxt.pins.bank_ir_priority    = st_r.prio[`SPFC_B_BANKPRIO];
    st_nxt.pins.crc_append          = st_r.pinfb[`SPFC_B_CRC];
    st_nxt.pins.bank_select_enable  = st_r.pinfb[`SPFC_B_BANKSEL];
    st_nxt.pins.crystal_freq_sel    = st_r.pinfb[`SPFC_B_CLKSEL];
    st_nxt.pins.drive_a_precomp_off = st_r.floppy[`SPFC_B_PRECA];
    st_nxt.pins.drive_b_precomp_off = st_r.floppy[`SPFC_B_PRECB];

    // Floppy rates per drive
    ta = st_r.floppy[1:0];
    tb = st_r.floppy[4:3];
    st_nxt.rate_a = rate_of(ta, rsel);
    st_nxt.rate_b = rate_of(tb, rsel);
    // FM has no 1M or 2M rate
    st_nxt.fm_a = (rsel != 2'h3) && !(ta == 2'h2 && rsel == 2'h1);
    st_nxt.fm_b = (rsel != 2'h3) && !(tb == 2'h2 && rsel == 2'h1);

    // Turnaround: on each direction change except one in the GO cycle, optionally hold off four chars
    st_nxt.prev_tx = IR_TX_DIR_I;
    case (st_r.turn_st)
      spfc_pkg::SPFC_T_IDLE: begin
        st_nxt.tx_allow = IR_TX_DIR_I;
        st_nxt.rx_allow = !IR_TX_DIR_I;
        if (IR_TX_DIR_I != st_r.prev_tx) begin
          if (IR_TX_DIR_I ? st_r.turn[`SPFC_B_TXWAIT]
                          : st_r.turn[`SPFC_B_RXWAIT]) begin
            st_nxt.tx_allow = 1'b0;
            st_nxt.rx_allow = 1'b0;
            st_nxt.turn_cnt = 2'(`SPFC_TURN_CHARS - 1);
            st_nxt.turn_st  = spfc_pkg::SPFC_T_WAIT;
          end
        end
      end
      spfc_pkg::SPFC_T_WAIT: begin
        st_nxt.tx_allow = 1'b0;
        st_nxt.rx_allow = 1'b0;
        // A further direction change restarts the hold-off
        if (IR_TX_DIR_I != st_r.prev_tx) begin
          st_nxt.turn_cnt = 2'(`SPFC_TURN_CHARS - 1);
        end else if (IR_CHAR_TICK_I) begin
          if (st_r.turn_cnt == 2'h0) begin
            st_nxt.turn_st = spfc_pkg::SPFC_T_GO;
          end else begin
            st_nxt.turn_cnt = st_r.turn_cnt - 2'h1;
          end
        end
      end
      spfc_pkg::SPFC_T_GO: begin
        st_nxt.tx_allow = IR_TX_DIR_I;
        st_nxt.rx_allow = !IR_TX_DIR_I;
        st_nxt.turn_st  = spfc_pkg::SPFC_T_IDLE;
      end
      default: begin
        st_nxt.turn_st = spfc_pkg::SPFC_T_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r          <= '0;
      st_r.turn     <= `SPFC_RST_TURN;
      st_r.prio     <= `SPFC_RST_PRIO;
      st_r.irqgio   <= `SPFC_RST_IRQGIO;
      st_r.firdma   <= `SPFC_RST_FIRDMA;
      st_r.pinfa    <= `SPFC_RST_PINFA;
      st_r.pinfb    <= `SPFC_RST_PINFB;
      st_r.floppy   <= `SPFC_RST_FLOPPY;
      st_r.turn_st  <= spfc_pkg::SPFC_T_IDLE;
      st_r.rx_allow <= 1'b1;
      st_r.rate_a   <= spfc_pkg::SPFC_R_500K;
      st_r.rate_b   <= spfc_pkg::SPFC_R_500K;
      st_r.fm_a     <= 1'b1;
      st_r.fm_b     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign AWREADY_O  = !st_r.awv;
  assign WREADY_O   = !st_r.wv;
  assign BVALID_O   = st_r.bvalid;
  assign BRESP_O    = st_r.bresp;
  assign ARREADY_O  = st_r.arready;
  assign RVALID_O   = st_r.rvalid;
  assign RDATA_O    = st_r.rdata;
  assign RRESP_O    = st_r.rresp;
  assign PINS_O     = st_r.pins;
  assign TX_ALLOW_O = st_r.tx_allow;
  assign RX_ALLOW_O = st_r.rx_allow;
  assign RATE_A_O   = st_r.rate_a;
  assign RATE_B_O   = st_r.rate_b;
  assign FM_A_O     = st_r.fm_a;
  assign FM_B_O     = st_r.fm_b;

endmodule
`default_nettype wire

// >>> verification/spfc_props.sv
// Concurrent checks on the ports of the pin function configuration block
`default_nettype none
module spfc_props (
  // Clock and reset
  input wire logic                    CLK_I,
  input wire logic                    RST_N_I,
  // Bus handshakes
  input wire logic                    AWVALID_I,
  input wire logic                    AWREADY_O,
  input wire logic                    WVALID_I,
  input wire logic                    WREADY_O,
  input wire logic                    BVALID_O,
  input wire logic                    BREADY_I,
  input wire logic [1:0]              BRESP_O,
  input wire logic                    ARVALID_I,
  input wire logic                    ARREADY_O,
  input wire logic                    RVALID_O,
  input wire logic                    RREADY_I,
  input wire logic [31:0]             RDATA_O,
  // Derived settings
  input wire spfc_pkg::spfc_pins_type PINS_O,
  input wire logic                    TX_ALLOW_O,
  input wire logic                    RX_ALLOW_O,
  input wire spfc_pkg::spfc_rate_type RATE_A_O,
  input wire logic                    FM_A_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  ////////////////////////////////////////////////////////////////////////////
  // Read answer: address pulse, then data valid
  sequence s_rd_ans;
    ARREADY_O ##1 RVALID_O;
  endsequence
  // Write answer: address half held, then response
  sequence s_wr_ans;
    !AWREADY_O ##1 BVALID_O;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (
    ARVALID_I && !ARREADY_O && !RVALID_O |=> s_rd_ans)
    else $error("read answer not on time");
  chk_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I
    && WREADY_O && !BVALID_O |=> s_wr_ans)
    else $error("write answer not on time");
  chk_arready_pulse: assert property (ARREADY_O |=> !ARREADY_O)
    else $error("address ready longer than one cycle");
  chk_bresp_stands: assert property (
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped early");
  chk_rdata_stands: assert property (
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped early");
  // Decode lands one edge after reset release, so skip that edge
  chk_tx_dma_onehot: assert property (
    $past(RST_N_I) |-> $onehot(PINS_O.fir_tx_dma_onehot))
    else $error("transmit channel select not one-hot");
  chk_rx_dma_onehot: assert property (
    $past(RST_N_I) |-> $onehot(PINS_O.fir_rx_dma_onehot))
    else $error("receive channel select not one-hot");
  chk_allow_exclusive: assert property (
    !(TX_ALLOW_O && RX_ALLOW_O))
    else $error("transmit and receive allowed together");
  chk_rate_fm_link: assert property (
    (RATE_A_O == spfc_pkg::SPFC_R_1M || RATE_A_O == spfc_pkg::SPFC_R_2M)
    == !FM_A_O)
    else $error("FM flag does not match rate");
endmodule

bind spfc_top spfc_props chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .BRESP_O(BRESP_O),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .PINS_O(PINS_O),
  .TX_ALLOW_O(TX_ALLOW_O), .RX_ALLOW_O(RX_ALLOW_O),
  .RATE_A_O(RATE_A_O), .FM_A_O(FM_A_O)
);
`default_nettype wire

// >>> verification/tb_superio_pin_function_config.sv
// Self-checking bench for the pin function configuration block
`default_nettype none
module tb_superio_pin_function_config;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // Bench drives
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        dir, tick, bank;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [1:0]  rsel;
  // Design answers
  logic        awready, wready, bvalid, arready, rvalid, tx, rx, fma, fmb;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  spfc_pkg::spfc_pins_type pins;
  spfc_pkg::spfc_rate_type ra, rb, er;
  int          n_mismatch = 0;
  int          checks_done = 0;
  // Register reset values, in address order
  logic [7:0]  rst_v [7] = '{8'h00, 8'h28, 8'h1e, 8'h00, 8'h00, 8'h10, 8'h00};

  spfc_top dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .AWADDR_I(awaddr), .WVALID_I(wvalid), .WREADY_O(wready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .BVALID_O(bvalid), .BREADY_I(bready),
    .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .ARADDR_I(araddr), .RVALID_O(rvalid), .RREADY_I(rready),
    .RDATA_O(rdata), .RRESP_O(rresp), .IR_TX_DIR_I(dir),
    .IR_CHAR_TICK_I(tick), .BANK_IR_SELECT_ZERO_MODE_I(bank), .RATE_SEL_I(rsel),
    .PINS_O(pins), .TX_ALLOW_O(tx), .RX_ALLOW_O(rx), .RATE_A_O(ra),
    .RATE_B_O(rb), .FM_A_O(fma), .FM_B_O(fmb)
  );

  // 20 MHz clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %0t: got %h expected %h", $time, g, e);
      n_mismatch++;
    end
  endtask

  // Write: both halves offered together, bready raised once bvalid seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // Late ready makes the response stand a cycle
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    // Late ready makes the read data stand a cycle
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    chk(rdata, d);
    chk(32'(rresp), 32'(e));
  endtask

  // Byte-lane shorthands
  task automatic w1(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'h0, d}, 4'h1, 2'h0);
  endtask
  task automatic r1(input logic [7:0] a, input logic [7:0] d);
    rd(a, {24'h0, d}, 2'h0);
  endtask

  // Register then decode need two edges; one spare
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Direction change; with wait, allow stays low until four ticks
  task automatic turn(input logic d, input logic w);
    @(posedge clk);
    dir <= d;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4 && w; i++) begin
      chk(32'({tx, rx}), 32'h0);
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    settle;
    chk(32'({tx, rx}), 32'({d, !d}));
  endtask

  // Expected MFM rate from table bits and rate bits
  function automatic spfc_pkg::spfc_rate_type exp_rate(
      input logic [1:0] t, input logic [1:0] r);
    if (r == 2'h3) return spfc_pkg::SPFC_R_1M;
    if (r == 2'h1 && t == 2'h2) return spfc_pkg::SPFC_R_2M;
    if (r == 2'h1 && t == 2'h1) return spfc_pkg::SPFC_R_500K;
    if (r == 2'h0) return spfc_pkg::SPFC_R_500K;
    return (r == 2'h1) ? spfc_pkg::SPFC_R_300K : spfc_pkg::SPFC_R_250K;
  endfunction

  // Verdict, reached from the tests or the watchdog
  task automatic report_and_stop;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, dir, tick, bank} = '0;
    {awaddr, araddr, wdata, wstrb, rsel} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, status, reset decode
    for (int i = 0; i < 7; i++) r1(8'(4 * i), rst_v[i]);
    rd(8'h20, 32'h3112, 2'h0);
    chk(32'({pins.irq_a_gio_sel, pins.irq_b_gio_sel}), 32'h1);
    chk(32'({pins.secondary_ir_enable, pins.crc_append}), 32'h3);
    // Unmapped, read-only status, masked lane
    wr(8'h24, 32'h0, 4'hf, 2'h2);
    rd(8'h24, 32'h0, 2'h2);
    wr(8'h20, 32'hffff, 4'hf, 2'h0);
    rd(8'h20, 32'h3112, 2'h0);
    w1(8'h00, 8'h80);
    settle;
    chk(32'(pins.pullup_disable), 32'h1);
    wr(8'h00, 32'h0, 4'he, 2'h0);
    r1(8'h00, 8'h80);
    w1(8'h00, 8'h00);
    settle;
    chk(32'(pins.pullup_disable), 32'h0);
    // Shared interrupt pins and secondary IR
    w1(8'h08, 8'h30);
    settle;
    chk(32'({pins.irq_a_gio_sel, pins.irq_b_gio_sel}), 32'h3);
    chk(32'(pins.secondary_ir_enable), 32'h0);
    // Every DMA code, plus one beyond the table
    for (int c = 0; c < 6; c++) begin
      w1(8'h0c, {c[3:0], c[3:0]});
      settle;
      chk(32'(pins.fir_tx_dma_onehot), (c < 5) ? 32'h1 << c : 32'h1);
      chk(32'(pins.fir_rx_dma_onehot), (c < 5) ? 32'h1 << c : 32'h1);
    end
    // Every two-bit pin function code
    for (int v = 0; v < 4; v++) begin
      w1(8'h10, {v[1:0], v[1:0], v[1:0], v[1:0]});
      settle;
      chk(32'(pins.first_pin_func), 32'(v));
      chk(32'(pins.second_pin_func), 32'(v));
      chk(32'(pins.third_pin_func), 32'(v));
      chk(32'(pins.irq_input_pin_func), 32'(v));
    end
    // Buffer pin codes; reserved bit 1 reads back zero
    for (int v = 0; v < 6; v++) begin
      w1(8'h14, {v[2:0], 5'h1e});
      r1(8'h14, {v[2:0], 5'h1c});
      settle;
      chk(32'(pins.buffer_pin_func), (v < 5) ? 32'(v) : 32'h0);
      chk(32'({pins.crc_append, pins.bank_select_enable}),
          32'h3);
      chk(32'(pins.crystal_freq_sel), 32'h1);
    end
    // Select-zero option taken from the bank when priority is set
    w1(8'h10, 8'h0f);
    w1(8'h14, 8'h60);
    w1(8'h04, 8'h38);
    @(posedge clk);
    bank <= 1'b1;
    settle;
    chk(32'({pins.third_pin_is_sel0, pins.irq_in_pin_is_sel0,
             pins.buffer_pin_is_sel0, pins.bank_ir_priority}), 32'hf);
    chk(32'({pins.crc_append, pins.bank_select_enable,
             pins.crystal_freq_sel}), 32'h0);
    @(posedge clk);
    bank <= 1'b0;
    settle;
    chk(32'({pins.third_pin_is_sel0, pins.irq_in_pin_is_sel0}),
        32'h0);
    // Rate tables against rate bits from outside
    for (int t = 0; t < 3; t++) begin
      w1(8'h18, {3'h7, t[1:0], 1'b0, t[1:0]});
      r1(8'h18, {3'h1, t[1:0], 1'b0, t[1:0]});
      chk(32'({pins.drive_a_precomp_off,
               pins.drive_b_precomp_off}), 32'h1);
      for (int r = 0; r < 4; r++) begin
        @(posedge clk);
        rsel <= r[1:0];
        settle;
        er = exp_rate(t[1:0], r[1:0]);
        chk(32'(ra), 32'(er));
        chk(32'(rb), 32'(er));
        chk(32'({fma, fmb}),
            (er == 3'h0 || er == 3'h4) ? 32'h0 : 32'h3);
      end
    end
    w1(8'h18, 8'h04);
    settle;
    chk(32'({pins.drive_a_precomp_off,
             pins.drive_b_precomp_off}), 32'h2);
    // Priority clear: configuration selection wins over the bank
    w1(8'h1c, 8'h01);
    w1(8'h04, 8'h28);
    settle;
    chk(32'({pins.third_pin_is_sel0, pins.bank_ir_priority}), 32'h2);
    // Turnaround waits in both directions, and without wait
    w1(8'h00, 8'h40);
    turn(1'b1, 1'b1);
    turn(1'b0, 1'b0);
    w1(8'h00, 8'h20);
    turn(1'b1, 1'b0);
    turn(1'b0, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
